// *** verilog/scsf_cfg.svh ***
// offsets, field positions and reset values of the status-flag block
// What this block does
// - rx ready set on character, cleared by read
// - chars while disabled show ready on enable
// - tx free needs enable, empty holding, and outside spi modes no break
// - break seen sticky until clear status
// - rx count done at zero, cleared on write
// - tx count done at zero, cleared on write
// - overrun sticky until clear status
// - stop bit low sticky until clear
// - parity fault sticky until clear status
// - idle expired, restart clears, zero value masks
// - drained when tx enabled and holding and shifter both empty
// - retry limit sticky until clear retry
// - tx exhausted when both tx counts zero
// - rx exhausted when both rx counts zero
// - nak sticky until clear nak
// - cts change sticky, status read clears
// - cts level mirrors the input pin
// - biphase error sticky until clear status
// - spi modes show reduced view, underrun bit10
// - spi underrun sticky until clear status
// - rx holding gives last char, read clears ready
// - bit 15 tells data or command char
`ifndef SCSF_CFG_SVH
`define SCSF_CFG_SVH
`define SCSF_CTRL_ADDR     32'h40024000
`define SCSF_MODE_ADDR     32'h40024004
`define SCSF_STATUS_ADDR   32'h40024014
`define SCSF_RXHOLD_ADDR   32'h40024018
`define SCSF_TXHOLD_ADDR   32'h4002401c
`define SCSF_TIMEOUT_ADDR  32'h40024024
`define SCSF_RXCNT_ADDR    32'h40024104
`define SCSF_RXNCNT_ADDR   32'h40024114
`define SCSF_TXCNT_ADDR    32'h4002410c
`define SCSF_TXNCNT_ADDR   32'h4002411c
`define SCSF_CMD_RXEN      4
`define SCSF_CMD_RXDIS     5
`define SCSF_CMD_TXEN      6
`define SCSF_CMD_TXDIS     7
`define SCSF_CMD_CLRSTA    8
`define SCSF_CMD_BREAK     9
`define SCSF_CMD_RESTART   11
`define SCSF_CMD_CLRRETRY  13
`define SCSF_CMD_CLRNAK    14
`define SCSF_ST_RXREADY    0
`define SCSF_ST_TXFREE     1
`define SCSF_ST_BREAK      2
`define SCSF_ST_RXDONE     3
`define SCSF_ST_TXDONE     4
`define SCSF_ST_OVERRUN    5
`define SCSF_ST_STOPERR    6
`define SCSF_ST_PARITY     7
`define SCSF_ST_IDLE       8
`define SCSF_ST_DRAINED    9
`define SCSF_ST_RETRY      10
`define SCSF_ST_UNDERRUN   10
`define SCSF_ST_TXEXH      11
`define SCSF_ST_RXEXH      12
`define SCSF_ST_NAK        13
`define SCSF_ST_CTSCHG     19
`define SCSF_ST_CTSLVL     23
`define SCSF_ST_BIPHASE    24
`define SCSF_RX_SYNC_BIT   15
`define SCSF_CHAR_W        9
`define SCSF_MODE_RESET    4'h0
`endif

// *** verilog/scsf_pkg.sv ***
// types of the status-flag block
package scsf_pkg;
  typedef enum logic [3:0] {
    SCSF_MODE_NORMAL     = 4'b0000,
    SCSF_MODE_SPI_MASTER = 4'b1110,
    SCSF_MODE_SPI_SLAVE  = 4'b1111
  } scsf_mode_t;
endpackage : scsf_pkg

// *** verilog/scsf_status_flags.sv ***
// status flags, receive holding and dma counters of the serial port
//
// Decided for this implementation: the plain strobed port.
`include "scsf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scsf_status_flags #(
  parameter int CW = 16,
  parameter int TW = 16
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic [31:0]             busAddr,
  input  wire logic [31:0]             busWrData,
  input  wire logic                    busWrite,
  input  wire logic                    busRead,
  output logic      [31:0]             busRdData,
  input  wire logic                    rxCharValid,
  input  wire logic [`SCSF_CHAR_W-1:0] rxChar,
  input  wire logic                    rxCharCommand,
  input  wire logic                    breakEvent,
  input  wire logic                    stopBitLow,
  input  wire logic                    parityFail,
  input  wire logic                    manchesterError,
  input  wire logic                    idleTimeoutEvent,
  input  wire logic                    retryLimitEvent,
  input  wire logic                    nakEvent,
  input  wire logic                    spiUnderrun,
  input  wire logic                    ctsIn,
  input  wire logic                    txShiftTake,
  input  wire logic                    txShiftEmpty,
  input  wire logic                    breakStarted,
  input  wire logic [1:0]              dmaStep,
  output logic                         rxEnabled,
  output logic                         txEnabled,
  output logic      [3:0]              portMode,
  output logic      [TW-1:0]           idleTimeoutValue,
  output logic                         idleTimerRestart,
  output logic                         breakRequest,
  output logic      [`SCSF_CHAR_W-1:0] txHoldData,
  output logic                         txHoldSync,
  output logic                         txHoldFull
);

  function automatic logic isSpiMode(input logic [3:0] m);
    isSpiMode = (m == scsf_pkg::SCSF_MODE_SPI_MASTER) ||
                (m == scsf_pkg::SCSF_MODE_SPI_SLAVE);
  endfunction : isSpiMode

  // bus decode
  logic ctrlWrite;
  logic statusRead;
  logic rxHoldRead;
  logic txHoldWrite;
  logic spiMode;
  assign ctrlWrite   = busWrite && (busAddr == `SCSF_CTRL_ADDR);
  assign statusRead  = busRead && (busAddr == `SCSF_STATUS_ADDR);
  assign rxHoldRead  = busRead && (busAddr == `SCSF_RXHOLD_ADDR);
  assign txHoldWrite = busWrite && (busAddr == `SCSF_TXHOLD_ADDR);
  assign spiMode     = isSpiMode(portMode);

  // command pulses
  logic cmdClrSta;
  logic cmdRestart;
  logic cmdClrRetry;
  logic cmdClrNak;
  logic cmdBreak;
  assign cmdClrSta   = ctrlWrite && busWrData[`SCSF_CMD_CLRSTA];
  assign cmdRestart  = ctrlWrite && busWrData[`SCSF_CMD_RESTART];
  assign cmdClrRetry = ctrlWrite && busWrData[`SCSF_CMD_CLRRETRY];
  assign cmdClrNak   = ctrlWrite && busWrData[`SCSF_CMD_CLRNAK];
  assign cmdBreak    = ctrlWrite && busWrData[`SCSF_CMD_BREAK];

  // enables, disable wins over enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxEnabled <= 1'b0;
    end else if (ctrlWrite && busWrData[`SCSF_CMD_RXDIS]) begin
      rxEnabled <= 1'b0;
    end else if (ctrlWrite && busWrData[`SCSF_CMD_RXEN]) begin
      rxEnabled <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txEnabled <= 1'b0;
    end else if (ctrlWrite && busWrData[`SCSF_CMD_TXDIS]) begin
      txEnabled <= 1'b0;
    end else if (ctrlWrite && busWrData[`SCSF_CMD_TXEN]) begin
      txEnabled <= 1'b1;
    end
  end

  // mode and time-out value
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      portMode <= `SCSF_MODE_RESET;
    end else if (busWrite && (busAddr == `SCSF_MODE_ADDR)) begin
      portMode <= busWrData[3:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idleTimeoutValue <= '0;
    end else if (busWrite && (busAddr == `SCSF_TIMEOUT_ADDR)) begin
      idleTimeoutValue <= busWrData[TW-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idleTimerRestart <= 1'b0;
    end else begin
      idleTimerRestart <= cmdRestart;
    end
  end

  // receive holding
  logic [`SCSF_CHAR_W-1:0] rxData;
  logic                    rxSync;
  logic                    rxReadyRaw;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxData <= '0;
      rxSync <= 1'b0;
    end else if (rxCharValid) begin
      rxData <= rxChar;
      rxSync <= rxCharCommand;
    end
  end

  // kept while disabled, shown once enabled again
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxReadyRaw <= 1'b0;
    end else if (rxCharValid) begin
      rxReadyRaw <= 1'b1;
    end else if (rxHoldRead) begin
      rxReadyRaw <= 1'b0;
    end
  end

  // sticky line errors
  logic overrunFlag;
  logic breakSeen;
  logic stopBitError;
  logic parityFault;
  logic biphaseError;
  logic underrunFlag;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overrunFlag <= 1'b0;
    end else if (rxCharValid && rxReadyRaw && !rxHoldRead) begin
      overrunFlag <= 1'b1;
    end else if (cmdClrSta) begin
      overrunFlag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      breakSeen <= 1'b0;
    end else if (breakEvent) begin
      breakSeen <= 1'b1;
    end else if (cmdClrSta) begin
      breakSeen <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stopBitError <= 1'b0;
    end else if (stopBitLow) begin
      stopBitError <= 1'b1;
    end else if (cmdClrSta) begin
      stopBitError <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      parityFault <= 1'b0;
    end else if (parityFail) begin
      parityFault <= 1'b1;
    end else if (cmdClrSta) begin
      parityFault <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      biphaseError <= 1'b0;
    end else if (manchesterError) begin
      biphaseError <= 1'b1;
    end else if (cmdClrSta) begin
      biphaseError <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      underrunFlag <= 1'b0;
    end else if (spiUnderrun && spiMode) begin
      underrunFlag <= 1'b1;
    end else if (cmdClrSta) begin
      underrunFlag <= 1'b0;
    end
  end

  // time-out, retry and nak
  logic idleExpired;
  logic retryLimitHit;
  logic nakFlag;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idleExpired <= 1'b0;
    end else if (idleTimeoutEvent && (idleTimeoutValue != '0)) begin
      idleExpired <= 1'b1;
    end else if (cmdRestart) begin
      idleExpired <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      retryLimitHit <= 1'b0;
    end else if (retryLimitEvent) begin
      retryLimitHit <= 1'b1;
    end else if (cmdClrRetry) begin
      retryLimitHit <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nakFlag <= 1'b0;
    end else if (nakEvent) begin
      nakFlag <= 1'b1;
    end else if (cmdClrNak) begin
      nakFlag <= 1'b0;
    end
  end

  // clear-to-send level and change
  logic ctsLevel;
  logic ctsToggled;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctsLevel <= 1'b0;
    end else begin
      ctsLevel <= ctsIn;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctsToggled <= 1'b0;
    end else if (ctsIn != ctsLevel) begin
      ctsToggled <= 1'b1;
    end else if (statusRead) begin
      ctsToggled <= 1'b0;
    end
  end

  // transmit holding and break request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txHoldData <= '0;
      txHoldSync <= 1'b0;
    end else if (txHoldWrite) begin
      txHoldData <= busWrData[`SCSF_CHAR_W-1:0];
      txHoldSync <= busWrData[`SCSF_RX_SYNC_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txHoldFull <= 1'b0;
    end else if (txHoldWrite) begin
      txHoldFull <= 1'b1;
    end else if (txShiftTake) begin
      txHoldFull <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      breakRequest <= 1'b0;
    end else if (cmdBreak) begin
      breakRequest <= 1'b1;
    end else if (breakStarted) begin
      breakRequest <= 1'b0;
    end
  end

  // dma counters, index 0 receive, 1 transmit
  logic [CW-1:0] dmaCount [2];
  logic [CW-1:0] dmaNext  [2];
  logic [1:0]    countDone;
  logic [1:0]    blockExhausted;
  logic [31:0]   cntAddr  [2];
  logic [31:0]   nextAddr [2];
  assign cntAddr[0]  = `SCSF_RXCNT_ADDR;
  assign cntAddr[1]  = `SCSF_TXCNT_ADDR;
  assign nextAddr[0] = `SCSF_RXNCNT_ADDR;
  assign nextAddr[1] = `SCSF_TXNCNT_ADDR;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_dma
      logic cntWrite;
      logic nextWrite;
      logic lastStep;
      assign cntWrite  = busWrite && (busAddr == cntAddr[ch]);
      assign nextWrite = busWrite && (busAddr == nextAddr[ch]);
      assign lastStep  = dmaStep[ch] && (dmaCount[ch] == CW'(1));

      // count and reload from the next count
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          dmaCount[ch] <= '0;
        end else if (cntWrite) begin
          dmaCount[ch] <= busWrData[CW-1:0];
        end else if (lastStep) begin
          dmaCount[ch] <= dmaNext[ch];
        end else if (dmaStep[ch] && (dmaCount[ch] != '0)) begin
          dmaCount[ch] <= dmaCount[ch] - CW'(1);
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          dmaNext[ch] <= '0;
        end else if (nextWrite) begin
          dmaNext[ch] <= busWrData[CW-1:0];
        end else if (lastStep) begin
          dmaNext[ch] <= '0;
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          countDone[ch] <= 1'b0;
        end else if (lastStep) begin
          countDone[ch] <= 1'b1;
        end else if (cntWrite || nextWrite) begin
          countDone[ch] <= 1'b0;
        end
      end

      assign blockExhausted[ch] = (dmaCount[ch] == '0) &&
                                  (dmaNext[ch] == '0);
    end
  endgenerate

  // status words
  logic [31:0] fullView;
  logic [31:0] spiView;
  logic        txFree;
  logic        txDrained;
  assign txFree    = txEnabled && !txHoldFull && !breakRequest;
  assign txDrained = txEnabled && !txHoldFull && txShiftEmpty;

  always_comb begin
    fullView                       = '0;
    fullView[`SCSF_ST_RXREADY]     = rxReadyRaw && rxEnabled;
    fullView[`SCSF_ST_TXFREE]      = txFree;
    fullView[`SCSF_ST_BREAK]       = breakSeen;
    fullView[`SCSF_ST_RXDONE]      = countDone[0];
    fullView[`SCSF_ST_TXDONE]      = countDone[1];
    fullView[`SCSF_ST_OVERRUN]     = overrunFlag;
    fullView[`SCSF_ST_STOPERR]     = stopBitError;
    fullView[`SCSF_ST_PARITY]      = parityFault;
    fullView[`SCSF_ST_IDLE]        = idleExpired && (idleTimeoutValue != '0);
    fullView[`SCSF_ST_DRAINED]     = txDrained;
    fullView[`SCSF_ST_RETRY]       = retryLimitHit;
    fullView[`SCSF_ST_TXEXH]       = blockExhausted[1];
    fullView[`SCSF_ST_RXEXH]       = blockExhausted[0];
    fullView[`SCSF_ST_NAK]         = nakFlag;
    fullView[`SCSF_ST_CTSCHG]      = ctsToggled;
    fullView[`SCSF_ST_CTSLVL]      = ctsLevel;
    fullView[`SCSF_ST_BIPHASE]     = biphaseError;
  end

  always_comb begin
    spiView                        = '0;
    spiView[`SCSF_ST_RXREADY]      = rxReadyRaw && rxEnabled;
    spiView[`SCSF_ST_TXFREE]       = txEnabled && !txHoldFull;
    spiView[`SCSF_ST_RXDONE]       = countDone[0];
    spiView[`SCSF_ST_TXDONE]       = countDone[1];
    spiView[`SCSF_ST_OVERRUN]      = overrunFlag;
    spiView[`SCSF_ST_DRAINED]      = txDrained;
    spiView[`SCSF_ST_UNDERRUN]     = underrunFlag;
    spiView[`SCSF_ST_TXEXH]        = blockExhausted[1];
    spiView[`SCSF_ST_RXEXH]        = blockExhausted[0];
  end

  // read data, one cycle after the strobe, zero elsewhere
  logic [31:0] next_busRdData;
  always_comb begin
    next_busRdData = '0;
    case (busAddr)
      `SCSF_STATUS_ADDR: begin
        next_busRdData = spiMode ? spiView : fullView;
      end
      `SCSF_RXHOLD_ADDR: begin
        next_busRdData[`SCSF_CHAR_W-1:0]  = rxData;
        next_busRdData[`SCSF_RX_SYNC_BIT] = rxSync;
      end
      `SCSF_MODE_ADDR: begin
        next_busRdData[3:0] = portMode;
      end
      `SCSF_TIMEOUT_ADDR: begin
        next_busRdData[TW-1:0] = idleTimeoutValue;
      end
      `SCSF_RXCNT_ADDR: begin
        next_busRdData[CW-1:0] = dmaCount[0];
      end
      `SCSF_RXNCNT_ADDR: begin
        next_busRdData[CW-1:0] = dmaNext[0];
      end
      `SCSF_TXCNT_ADDR: begin
        next_busRdData[CW-1:0] = dmaCount[1];
      end
      `SCSF_TXNCNT_ADDR: begin
        next_busRdData[CW-1:0] = dmaNext[1];
      end
      default: begin
        next_busRdData = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busRdData <= '0;
    end else if (busRead) begin
      busRdData <= next_busRdData;
    end else begin
      busRdData <= '0;
    end
  end

endmodule : scsf_status_flags
`default_nettype wire

// *** dv/scsf_status_flags_checker.sv ***
// port assertions of the status-flag block
`include "scsf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scsf_status_flags_checker (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic [31:0]             busAddr,
  input wire logic [31:0]             busWrData,
  input wire logic                    busWrite,
  input wire logic                    busRead,
  input wire logic [31:0]             busRdData,
  input wire logic                    ctsIn,
  input wire logic [3:0]              portMode,
  input wire logic                    rxEnabled,
  input wire logic                    txEnabled,
  input wire logic                    idleTimerRestart,
  input wire logic                    breakRequest,
  input wire logic [`SCSF_CHAR_W-1:0] txHoldData,
  input wire logic                    txHoldFull
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic                    stRd, ctlWr, spi, restartCmd, holdWr;
  logic [`SCSF_CHAR_W-1:0] wrChar;
  assign stRd       = busRead && busAddr == `SCSF_STATUS_ADDR;
  assign ctlWr      = busWrite && busAddr == `SCSF_CTRL_ADDR;
  assign holdWr     = busWrite && busAddr == `SCSF_TXHOLD_ADDR;
  assign spi        = portMode[3:1] == 3'b111;
  assign restartCmd = ctlWr && busWrData[11];
  assign wrChar     = busWrData[`SCSF_CHAR_W-1:0];
  a_rdata_idle: assert property (!busRead |=> busRdData == 32'h0)
    else $error("read data not zero outside read");
  a_cts_level: assert property (stRd && !spi && !$past(rst) |=> busRdData[23] == $past(ctsIn, 2))
    else $error("cts level bit wrong");
  a_spi_view: assert property (stRd && spi |=> (busRdData & 32'h018821c4) == 32'h0)
    else $error("spi status shows hidden bits");
  a_receive_ready_flag_off: assert property (stRd && !rxEnabled |=> !busRdData[0])
    else $error("rx ready while disabled");
  a_txoff_flags: assert property (stRd && !txEnabled |=> (busRdData & 32'h202) == 32'h0)
    else $error("tx flags while disabled");
  a_restart_pulse: assert property (idleTimerRestart == $past(restartCmd))
    else $error("restart pulse mismatch");
  a_tx_enable: assert property (ctlWr && busWrData[7:6] == 2'b01 |=> txEnabled)
    else $error("tx not enabled");
  a_tx_disable: assert property (ctlWr && busWrData[7] |=> !txEnabled)
    else $error("tx not disabled");
  a_hold_write: assert property (holdWr |=> txHoldFull && txHoldData == $past(wrChar))
    else $error("tx holding not taken");
  a_break_req: assert property (ctlWr && busWrData[9] |=> breakRequest)
    else $error("break not pending");
  a_rx_enable: assert property (ctlWr && busWrData[5:4] == 2'b01 |=> rxEnabled)
    else $error("rx not enabled");
  c_spi_read: cover property (stRd && spi);
  c_restart: cover property (restartCmd);
  c_cts_read: cover property (stRd && ctsIn);
endmodule : scsf_status_flags_checker
bind scsf_status_flags scsf_status_flags_checker scsf_status_flags_checker_i (
  .ref_clk(ref_clk), .rst(rst), .busAddr(busAddr), .busWrData(busWrData),
  .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData), .ctsIn(ctsIn),
  .portMode(portMode), .rxEnabled(rxEnabled), .txEnabled(txEnabled),
  .idleTimerRestart(idleTimerRestart), .breakRequest(breakRequest),
  .txHoldData(txHoldData), .txHoldFull(txHoldFull));
`default_nettype wire

// *** dv/scsf_line_partner.sv ***
// far-side model: framing events, cts pin, shifter and dma pulses
`timescale 1ns/1ps
`default_nettype none
module scsf_line_partner (
  input  wire logic       ref_clk,
  output logic            rxCharValid,
  output logic [8:0]      rxChar,
  output logic            rxCharCommand,
  output logic [7:0]      ev,
  output logic            ctsIn,
  output logic            txShiftTake,
  output logic            txShiftEmpty,
  output logic            breakStarted,
  output logic [1:0]      dmaStep
);
  initial begin
    {rxCharValid, rxChar, rxCharCommand, ev, ctsIn} = '0;
    {txShiftTake, breakStarted, dmaStep} = '0;
    txShiftEmpty = 1'b1;
  end
  // one-cycle event, dma, take and break-start pulses
  task automatic pulse(input logic [7:0] e, input logic [1:0] d, input logic tk,
                       input logic bs);
    @(posedge ref_clk);
    ev <= e;
    dmaStep <= d;
    txShiftTake <= tk;
    breakStarted <= bs;
    @(posedge ref_clk);
    ev <= 8'h00;
    dmaStep <= 2'b00;
    txShiftTake <= 1'b0;
    breakStarted <= 1'b0;
  endtask : pulse
  // complete character, line data not held after it
  task automatic send_char(input logic [8:0] c, input logic cmd);
    @(posedge ref_clk);
    rxCharValid <= 1'b1;
    rxChar <= c;
    rxCharCommand <= cmd;
    @(posedge ref_clk);
    rxCharValid <= 1'b0;
    rxChar <= ~c;
    rxCharCommand <= ~cmd;
  endtask : send_char
  task automatic set_cts(input logic v);
    @(posedge ref_clk);
    ctsIn <= v;
  endtask : set_cts
endmodule : scsf_line_partner
`default_nettype wire

// *** dv/scsf_status_flags_bench.sv ***
// self-checking bench of the status-flag block
`include "scsf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scsf_status_flags_bench;
  typedef struct {
    logic [7:0] ev;
    int         bitn;
    int         clr;
  } scsf_row_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] busAddr = '0, busWrData = '0, busRdData, rdVal;
  logic        busWrite = 1'b0, busRead = 1'b0;
  logic        rxCharValid, rxCharCommand, ctsIn, txShiftTake, txShiftEmpty, breakStarted;
  logic [8:0]  rxChar;
  logic [7:0]  ev;
  logic [1:0]  dmaStep;
  logic [3:0]  portMode;
  logic [15:0] idleTimeoutValue;
  logic        txHoldSync;
  int          error_cnt = 0, cmp_count = 0, cycles = 0;
  // event pulse, status bit, clearing command bit
  scsf_row_t   rows[7] = '{'{8'h01, 2, 8}, '{8'h02, 6, 8}, '{8'h04, 7, 8}, '{8'h08, 24, 8},
                           '{8'h10, 8, 11}, '{8'h20, 10, 13}, '{8'h40, 13, 14}};
  scsf_status_flags scsf_status_flags_i (
    .ref_clk(ref_clk), .rst(rst), .busAddr(busAddr), .busWrData(busWrData),
    .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxCharCommand(rxCharCommand),
    .breakEvent(ev[0]), .stopBitLow(ev[1]), .parityFail(ev[2]), .manchesterError(ev[3]),
    .idleTimeoutEvent(ev[4]), .retryLimitEvent(ev[5]), .nakEvent(ev[6]),
    .spiUnderrun(ev[7]), .ctsIn(ctsIn), .txShiftTake(txShiftTake),
    .txShiftEmpty(txShiftEmpty), .breakStarted(breakStarted), .dmaStep(dmaStep),
    .rxEnabled(), .txEnabled(), .portMode(portMode), .idleTimeoutValue(idleTimeoutValue),
    .idleTimerRestart(), .breakRequest(), .txHoldData(), .txHoldSync(txHoldSync),
    .txHoldFull());
  scsf_line_partner scsf_line_partner_i (
    .ref_clk(ref_clk), .rxCharValid(rxCharValid), .rxChar(rxChar),
    .rxCharCommand(rxCharCommand), .ev(ev), .ctsIn(ctsIn), .txShiftTake(txShiftTake),
    .txShiftEmpty(txShiftEmpty), .breakStarted(breakStarted), .dmaStep(dmaStep));
  always #25 ref_clk = ~ref_clk;
  task automatic end_of_test();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busWrite <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge ref_clk);
    busWrite <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [31:0] a);
    @(posedge ref_clk);
    busRead <= 1'b1;
    busAddr <= a;
    @(posedge ref_clk);
    busRead <= 1'b0;
    @(posedge ref_clk);
    rdVal = busRdData;
  endtask : rd_reg
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd_reg(`SCSF_STATUS_ADDR);
    chk("status", rdVal & m, e);
  endtask : st
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    st(32'hffffffff, 32'h00001800);
    rd_reg(`SCSF_MODE_ADDR);
    chk("mode", rdVal, 32'h0);
    rd_reg(32'h40024ff0);
    chk("unmapped", rdVal, 32'h0);
    wr(`SCSF_TIMEOUT_ADDR, 32'h5);
    rd_reg(`SCSF_TIMEOUT_ADDR);
    chk("timeout", rdVal, 32'h5);
    chk("timeout port", 32'(idleTimeoutValue), 32'h5);
    foreach (rows[i]) begin
      scsf_line_partner_i.pulse(rows[i].ev, 2'b00, 1'b0, 1'b0);
      st(32'h1 << rows[i].bitn, 32'h1 << rows[i].bitn);
      st(32'h1 << rows[i].bitn, 32'h1 << rows[i].bitn);
      wr(`SCSF_CTRL_ADDR, 32'h1 << rows[i].clr);
      st(32'h1 << rows[i].bitn, 32'h0);
    end
    wr(`SCSF_CTRL_ADDR, 32'h10);
    scsf_line_partner_i.send_char(9'h1a5, 1'b1);
    st(32'h21, 32'h1);
    rd_reg(`SCSF_RXHOLD_ADDR);
    chk("rx holding", rdVal, 32'h000081a5);
    st(32'h1, 32'h0);
    scsf_line_partner_i.send_char(9'h0f0, 1'b0);
    scsf_line_partner_i.send_char(9'h00f, 1'b0);
    st(32'h21, 32'h21);
    rd_reg(`SCSF_RXHOLD_ADDR);
    chk("rx holding", rdVal, 32'h0000000f);
    wr(`SCSF_CTRL_ADDR, 32'h120);
    scsf_line_partner_i.send_char(9'h055, 1'b0);
    st(32'h21, 32'h0);
    wr(`SCSF_CTRL_ADDR, 32'h10);
    st(32'h1, 32'h1);
    st(32'h202, 32'h0);
    wr(`SCSF_CTRL_ADDR, 32'h40);
    st(32'h202, 32'h202);
    wr(`SCSF_TXHOLD_ADDR, 32'h8123);
    st(32'h202, 32'h0);
    chk("tx sync", 32'(txHoldSync), 32'h1);
    scsf_line_partner_i.pulse(8'h00, 2'b00, 1'b1, 1'b0);
    st(32'h202, 32'h202);
    wr(`SCSF_CTRL_ADDR, 32'h200);
    st(32'h2, 32'h0);
    scsf_line_partner_i.pulse(8'h00, 2'b00, 1'b0, 1'b1);
    st(32'h2, 32'h2);
    wr(`SCSF_RXCNT_ADDR, 32'h1);
    wr(`SCSF_RXNCNT_ADDR, 32'h1);
    st(32'h1008, 32'h0);
    scsf_line_partner_i.pulse(8'h00, 2'b01, 1'b0, 1'b0);
    st(32'h1008, 32'h8);
    scsf_line_partner_i.pulse(8'h00, 2'b01, 1'b0, 1'b0);
    st(32'h1008, 32'h1008);
    wr(`SCSF_RXNCNT_ADDR, 32'h2);
    st(32'h1008, 32'h0);
    wr(`SCSF_TXCNT_ADDR, 32'h1);
    st(32'h810, 32'h0);
    scsf_line_partner_i.pulse(8'h00, 2'b10, 1'b0, 1'b0);
    st(32'h810, 32'h810);
    wr(`SCSF_TXNCNT_ADDR, 32'h0);
    st(32'h810, 32'h800);
    scsf_line_partner_i.set_cts(1'b1);
    repeat (2) @(posedge ref_clk);
    st(32'h880000, 32'h880000);
    st(32'h880000, 32'h800000);
    for (int m = 14; m < 16; m++) begin
      wr(`SCSF_MODE_ADDR, 32'(m));
      scsf_line_partner_i.pulse(8'h84, 2'b00, 1'b0, 1'b0);
      st(32'h008804a0, 32'h400);
      chk("mode port", 32'(portMode), 32'(m));
      wr(`SCSF_CTRL_ADDR, 32'h100);
      st(32'h400, 32'h0);
    end
    wr(`SCSF_MODE_ADDR, 32'h0);
    scsf_line_partner_i.pulse(8'h10, 2'b00, 1'b0, 1'b0);
    st(32'h100, 32'h100);
    wr(`SCSF_TIMEOUT_ADDR, 32'h0);
    scsf_line_partner_i.pulse(8'h10, 2'b00, 1'b0, 1'b0);
    st(32'h100, 32'h0);
    chk("timeout port", 32'(idleTimeoutValue), 32'h0);
    end_of_test();
  end
endmodule : scsf_status_flags_bench
`default_nettype wire
